// File: src/gpib_service_request_status.sv
`timescale 1ns/1ps
module gpib_service_request_status
    import srq_pkg::*;
(
    // Clock, reset and enable
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    // Event sources
    input  wire logic [7:0]        std_event,
    input  wire logic [7:0]        process_event,
    input  wire logic [7:0]        gauge_event,
    input  wire logic [7:0]        instr_error_event,
    input  wire logic [7:0]        status_aux,
    // Bus interface side
    input  wire logic              serial_poll,
    output logic      [7:0]        poll_status,
    output logic                   srq,
    // Interrupt
    output logic                   irq
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] reset_pipe;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_pipe <= 2'h0;
        end else begin
            reset_pipe <= {reset_pipe[0], 1'b1};
        end
    end

    assign rst_n = reset_pipe[1];

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0]       sre;
        logic [7:0]       std_en;
        logic [7:0]       process_en;
        logic [7:0]       gauge_en;
        logic [7:0]       instr_en;
        logic [INT_W-1:0] int_status;
        logic [INT_W-1:0] int_mask;
        logic [7:0]       rdata;
        logic [7:0]       poll_status;
        logic             srq;
        logic             irq;
    } state_type;

    state_type state;
    state_type next_state;

    // ************************************************************
    // Event status words
    // ************************************************************
    logic [NUM_WORDS-1:0][7:0] word_set;
    logic [NUM_WORDS-1:0][7:0] word_en;
    logic [NUM_WORDS-1:0][7:0] word_val;
    logic [NUM_WORDS-1:0]      word_sum;
    logic [NUM_WORDS-1:0]      read_clear;

    assign word_set[WORD_STD]     = std_event;
    assign word_set[WORD_PROCESS] = process_event;
    assign word_set[WORD_GAUGE]   = gauge_event;
    assign word_set[WORD_INSTR]   = instr_error_event;
    assign word_en[WORD_STD]      = state.std_en;
    assign word_en[WORD_PROCESS]  = state.process_en;
    assign word_en[WORD_GAUGE]    = state.gauge_en;
    assign word_en[WORD_INSTR]    = state.instr_en;

    // Reading a word is what clears it.
    assign read_clear = reg_read ? word_hit(reg_addr) : '0;

    for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
        event_status_word u_word (
            .core_clk   (core_clk),
            .rst_n      (rst_n),
            .clk_en     (clk_en),
            .set_pulse  (word_set[w]),
            .enable     (word_en[w]),
            .read_clear (read_clear[w]),
            .word       (word_val[w]),
            .summary    (word_sum[w])
        );
    end

    // ************************************************************
    // Status byte and request engine
    // ************************************************************
    srq_if      link ();
    logic [7:0] status_byte;

    always_comb begin
        status_byte              = status_aux & STB_AUX_MASK;
        status_byte[STB_PROCESS] = word_sum[WORD_PROCESS];
        status_byte[STB_GAUGE]   = word_sum[WORD_GAUGE];
        status_byte[STB_INSTR]   = word_sum[WORD_INSTR];
        status_byte[STB_STD]     = word_sum[WORD_STD];
        status_byte[STB_RQS]     = link.srq;
    end

    assign link.status_byte = status_byte;
    assign link.enable      = state.sre;
    assign link.poll        = serial_poll;

    srq_engine u_engine (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .link     (link)
    );

    // ************************************************************
    // Register port and interrupt
    // ************************************************************
    logic             wr_hit;
    logic [INT_W-1:0] int_event;

    always_comb begin
        next_state = state;
        wr_hit     = reg_write;
        int_event  = '0;
        int_event[INT_SRQ]  = link.fire;
        int_event[INT_POLL] = serial_poll;

        // Writes.
        if (wr_hit) begin
            if (is_sre_bit(reg_addr)) begin
                next_state.sre[reg_addr[2:0]] = reg_wdata[0];
            end else begin
                case (reg_addr)
                    ADDR_SRE: begin
                        next_state.sre = reg_wdata;
                    end
                    ADDR_STD_EN: begin
                        next_state.std_en = reg_wdata;
                    end
                    ADDR_PROCESS_EN: begin
                        next_state.process_en = reg_wdata;
                    end
                    ADDR_GAUGE_EN: begin
                        next_state.gauge_en = reg_wdata;
                    end
                    ADDR_INSTR_EN: begin
                        next_state.instr_en = reg_wdata;
                    end
                    ADDR_INT_STATUS: begin
                        next_state.int_status = state.int_status & ~reg_wdata[INT_W-1:0];
                    end
                    ADDR_INT_MASK: begin
                        next_state.int_mask = reg_wdata[INT_W-1:0];
                    end
                    default: begin
                        next_state.int_mask = state.int_mask;
                    end
                endcase
            end
        end

        // An event in the clearing cycle still sets its bit.
        next_state.int_status = next_state.int_status | int_event;

        // Reads answer in the following cycle only; unmapped reads give zero.
        next_state.rdata = '0;
        if (reg_read) begin
            if (is_sre_bit(reg_addr)) begin
                next_state.rdata = {7'h00, state.sre[reg_addr[2:0]]};
            end else begin
                case (reg_addr)
                    ADDR_SRE: begin
                        next_state.rdata = state.sre;
                    end
                    ADDR_STATUS: begin
                        next_state.rdata = status_byte;
                    end
                    ADDR_STD_EVENT: begin
                        next_state.rdata = word_val[WORD_STD];
                    end
                    ADDR_PROCESS: begin
                        next_state.rdata = word_val[WORD_PROCESS];
                    end
                    ADDR_GAUGE: begin
                        next_state.rdata = word_val[WORD_GAUGE];
                    end
                    ADDR_INSTR_ERR: begin
                        next_state.rdata = word_val[WORD_INSTR];
                    end
                    ADDR_STD_EN: begin
                        next_state.rdata = state.std_en;
                    end
                    ADDR_PROCESS_EN: begin
                        next_state.rdata = state.process_en;
                    end
                    ADDR_GAUGE_EN: begin
                        next_state.rdata = state.gauge_en;
                    end
                    ADDR_INSTR_EN: begin
                        next_state.rdata = state.instr_en;
                    end
                    ADDR_INT_STATUS: begin
                        next_state.rdata = {6'h00, state.int_status};
                    end
                    ADDR_INT_MASK: begin
                        next_state.rdata = {6'h00, state.int_mask};
                    end
                    default: begin
                        next_state.rdata = '0;
                    end
                endcase
            end
        end

        // Outputs are re-registered so the top drives only from flops.
        // This costs one cycle of lag on the request pin against the engine.
        next_state.srq         = link.srq;
        next_state.poll_status = status_byte;
        next_state.irq         = |(next_state.int_status & state.int_mask);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state.sre         <= SRE_RESET;
            state.std_en      <= EN_RESET;
            state.process_en  <= EN_RESET;
            state.gauge_en    <= EN_RESET;
            state.instr_en    <= EN_RESET;
            state.int_status  <= INT_RESET;
            state.int_mask    <= INT_RESET;
            state.rdata       <= 8'h00;
            state.poll_status <= 8'h00;
            state.srq         <= 1'b0;
            state.irq         <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign reg_rdata   = state.rdata;
    assign poll_status = state.poll_status;
    assign srq         = state.srq;
    assign irq         = state.irq;

endmodule

// File: src/srq_pkg.sv
package srq_pkg;

    // ************************************************************
    // Register port geometry
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [4:0] ADDR_SRE         = 5'h00;
    localparam logic [4:0] ADDR_STATUS      = 5'h01;
    localparam logic [4:0] ADDR_STD_EVENT   = 5'h02;
    localparam logic [4:0] ADDR_PROCESS     = 5'h03;
    localparam logic [4:0] ADDR_GAUGE       = 5'h04;
    localparam logic [4:0] ADDR_INSTR_ERR   = 5'h05;
    localparam logic [4:0] ADDR_STD_EN      = 5'h06;
    localparam logic [4:0] ADDR_PROCESS_EN  = 5'h07;
    localparam logic [4:0] ADDR_GAUGE_EN    = 5'h08;
    localparam logic [4:0] ADDR_INSTR_EN    = 5'h09;
    localparam logic [4:0] ADDR_INT_STATUS  = 5'h0A;
    localparam logic [4:0] ADDR_INT_MASK    = 5'h0B;
    localparam logic [1:0] ADDR_SRE_BIT_TAG = 2'h2;

    // ************************************************************
    // Status byte layout
    // ************************************************************
    localparam int STB_PROCESS = 0;
    localparam int STB_GAUGE   = 1;
    localparam int STB_INSTR   = 2;
    localparam int STB_STD     = 5;
    localparam int STB_RQS     = 6;
    localparam logic [7:0] STB_AUX_MASK     = 8'h98;
    localparam logic [7:0] SRQ_TRIGGER_MASK = 8'hBF;

    // ************************************************************
    // Event words and interrupt bits
    // ************************************************************
    localparam int WORD_STD     = 0;
    localparam int WORD_PROCESS = 1;
    localparam int WORD_GAUGE   = 2;
    localparam int WORD_INSTR   = 3;
    localparam int NUM_WORDS    = 4;
    localparam int INT_SRQ      = 0;
    localparam int INT_POLL     = 1;
    localparam int INT_W        = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]       SRE_RESET  = 8'h00;
    localparam logic [7:0]       EN_RESET   = 8'h00;
    localparam logic [7:0]       WORD_RESET = 8'h00;
    localparam logic [INT_W-1:0] INT_RESET  = 2'h0;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic is_sre_bit(input logic [ADDR_W-1:0] addr);
        return addr[4:3] == ADDR_SRE_BIT_TAG;
    endfunction

    function automatic logic [NUM_WORDS-1:0] word_hit(input logic [ADDR_W-1:0] addr);
        logic [NUM_WORDS-1:0] hit;
        hit               = '0;
        hit[WORD_STD]     = addr == ADDR_STD_EVENT;
        hit[WORD_PROCESS] = addr == ADDR_PROCESS;
        hit[WORD_GAUGE]   = addr == ADDR_GAUGE;
        hit[WORD_INSTR]   = addr == ADDR_INSTR_ERR;
        return hit;
    endfunction

endpackage

// File: src/srq_if.sv
`timescale 1ns/1ps
interface srq_if;
    logic [7:0] status_byte;
    logic [7:0] enable;
    logic       poll;
    logic       srq;
    logic       fire;

    modport engine (
        input  status_byte,
        input  enable,
        input  poll,
        output srq,
        output fire
    );

    modport owner (
        output status_byte,
        output enable,
        output poll,
        input  srq,
        input  fire
    );
endinterface

// File: src/event_status_word.sv
`timescale 1ns/1ps
module event_status_word
    import srq_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // Event side
    input  wire logic [7:0] set_pulse,
    input  wire logic [7:0] enable,
    input  wire logic       read_clear,
    output logic      [7:0] word,
    output logic            summary
);

    typedef struct packed {
        logic [7:0] word;
    } state_type;

    state_type state;
    state_type next_state;

    // Read clears the word, but an event in the same cycle still lands.
    always_comb begin
        next_state = state;
        if (read_clear) begin
            next_state.word = '0;
        end
        next_state.word = next_state.word | set_pulse;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state.word <= WORD_RESET;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign word    = state.word;
    assign summary = |(state.word & enable);

endmodule

// File: src/srq_engine.sv
`timescale 1ns/1ps
module srq_engine
    import srq_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // Status byte and request
    srq_if.engine     link
);

    typedef struct packed {
        logic [7:0] spent;
        logic       srq;
    } state_type;

    state_type  state;
    state_type  next_state;
    logic [7:0] fresh;

    // A bit that has already raised a request stays spent until it drops.
    // The request bit itself is kept out so the request cannot feed itself.
    always_comb begin
        fresh      = link.status_byte & link.enable & SRQ_TRIGGER_MASK & ~state.spent;
        next_state = state;
        next_state.spent = (state.spent | fresh) & link.status_byte;
        if (link.poll) begin
            next_state.srq = 1'b0;
        end
        if (|fresh) begin
            next_state.srq = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign link.srq  = state.srq;
    assign link.fire = |fresh & clk_en;

endmodule

// File: sim/gpib_service_request_status_asserts.sv
`timescale 1ns/1ps
module gpib_service_request_status_asserts
    import srq_pkg::*;
(
    // Clock, reset and register port
    input wire logic              core_clk, reset_n, clk_en, reg_write, reg_read,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
    // Events, bus side and interrupt
    input wire logic [7:0]        std_event, process_event, gauge_event, instr_error_event,
    input wire logic [7:0]        status_aux, poll_status,
    input wire logic              serial_poll, srq, irq
);
    // ****************
    // Port-side mirror
    // ****************
    // The enable register is mirrored from port writes, so no check needs a view inside.
    logic [7:0] sre_sh;
    logic [7:0] aux_d;
    logic [1:0] quiet_d;
    logic       sre_bit_d;
    logic       quiet;

    assign quiet = clk_en && !reg_write && status_aux == aux_d
        && {std_event, process_event, gauge_event, instr_error_event} == 32'h0;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sre_sh    <= SRE_RESET;
            aux_d     <= 8'h00;
            quiet_d   <= 2'h0;
            sre_bit_d <= 1'b0;
        end else begin
            aux_d     <= status_aux;
            quiet_d   <= {quiet_d[0], quiet};
            sre_bit_d <= sre_sh[reg_addr[2:0]];
            if (clk_en && reg_write && reg_addr == ADDR_SRE) begin
                sre_sh <= reg_wdata;
            end else if (clk_en && reg_write && reg_addr[4:3] == 2'h2) begin
                sre_sh[reg_addr[2:0]] <= reg_wdata[0];
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // A poll only counts when no fresh cause could re-fire the request beside it.
    sequence s_poll_quiet;
        serial_poll && quiet && quiet_d == 2'h3 ##1 quiet ##1 quiet;
    endsequence
    sequence s_sre_load;
        clk_en && reg_write && reg_addr == ADDR_SRE ##1 !reg_write ##1 clk_en && reg_read && reg_addr == ADDR_SRE;
    endsequence
    sequence s_std_read;
        clk_en && reg_read && reg_addr == ADDR_STD_EVENT && std_event == 8'h00 ##1 std_event == 8'h00;
    endsequence

    property p_reset_low;
        $rose(reset_n) |-> (!srq && !irq && reg_rdata == 8'h00) ##1 !srq;
    endproperty
    property p_aux_fire;
        clk_en && (status_aux & ~aux_d & sre_sh & STB_AUX_MASK) != 8'h00 |-> ##[1:3] srq;
    endproperty
    property p_cause;
        $rose(srq) |-> ($past(poll_status) & $past(sre_sh) & SRQ_TRIGGER_MASK) != 8'h00;
    endproperty
    property p_poll_clear;
        s_poll_quiet |=> !srq;
    endproperty
    property p_sre_read;
        clk_en && reg_read && reg_addr == ADDR_SRE |=> reg_rdata == $past(sre_sh);
    endproperty
    property p_sre_bit_read;
        clk_en && reg_read && reg_addr[4:3] == 2'h2 |=> reg_rdata == {7'h00, sre_bit_d};
    endproperty
    property p_sre_load;
        s_sre_load |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_std_clear;
        s_std_read |=> !poll_status[STB_STD];
    endproperty

    a_reset_low: assert property (p_reset_low) else $error("Output high after reset");
    a_aux_fire: assert property (p_aux_fire) else $error("Enabled rise gave no request");
    a_cause: assert property (p_cause) else $error("Request without enabled status bit");
    a_poll_clear: assert property (p_poll_clear) else $error("Request kept after poll");
    a_sre_read: assert property (p_sre_read) else $error("Enable byte read wrong");
    a_sre_bit_read: assert property (p_sre_bit_read) else $error("Enable bit read wrong");
    a_sre_load: assert property (p_sre_load) else $error("Enable byte not loaded");
    a_std_clear: assert property (p_std_clear) else $error("Summary kept after read");
endmodule

bind gpib_service_request_status gpib_service_request_status_asserts checker_inst (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .std_event(std_event), .process_event(process_event), .gauge_event(gauge_event),
    .instr_error_event(instr_error_event), .status_aux(status_aux), .poll_status(poll_status),
    .serial_poll(serial_poll), .srq(srq), .irq(irq)
);

// File: sim/serial_poll_controller.sv
`timescale 1ns/1ps
module serial_poll_controller (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Bench control
    input  wire logic [3:0] poll_delay,
    // Device side
    input  wire logic       srq,
    output logic            serial_poll
);
    // A hold-off after each poll stops a second poll while the request drains.
    logic [3:0] wait_cnt;
    logic [2:0] guard;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_poll <= 1'b0;
            wait_cnt    <= 4'h0;
            guard       <= 3'h0;
        end else begin
            serial_poll <= 1'b0;
            if (guard != 3'h0) begin
                guard <= guard - 3'h1;
            end else if (srq && wait_cnt == poll_delay) begin
                serial_poll <= 1'b1;
                wait_cnt    <= 4'h0;
                guard       <= 3'h4;
            end else begin
                wait_cnt <= srq ? wait_cnt + 4'h1 : 4'h0;
            end
        end
    end
endmodule

// File: sim/gpib_service_request_status_tb.sv
`timescale 1ns/1ps
module gpib_service_request_status_tb
    import srq_pkg::*;
;
    logic       core_clk     = 1'b0;
    logic       reset_n      = 1'b0;
    logic [4:0] reg_addr     = 5'h00;
    logic [7:0] reg_wdata    = 8'h00;
    logic       reg_write    = 1'b0;
    logic       reg_read     = 1'b0;
    logic [7:0] status_aux   = 8'h00;
    logic [7:0] ev [4]       = '{default: 8'h00};
    logic [3:0] poll_delay   = 4'h2;
    logic       clk_en       = 1'b1;
    logic [7:0] reg_rdata;
    logic [7:0] poll_status;
    logic       serial_poll;
    logic       srq;
    logic       irq;
    int         n_mismatch   = 0;
    int         total_checks = 0;

    always #2.5 core_clk = ~core_clk;

    gpib_service_request_status dut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .std_event(ev[WORD_STD]), .process_event(ev[WORD_PROCESS]), .gauge_event(ev[WORD_GAUGE]),
        .instr_error_event(ev[WORD_INSTR]), .status_aux(status_aux), .serial_poll(serial_poll),
        .poll_status(poll_status), .srq(srq), .irq(irq)
    );

    serial_poll_controller partner (
        .core_clk(core_clk), .reset_n(reset_n), .poll_delay(poll_delay),
        .srq(srq), .serial_poll(serial_poll)
    );

    // ****************
    // Bus and checks
    // ****************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic skip(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic pulse(input int w, input logic [7:0] v);
        @(posedge core_clk);
        ev[w] <= v;
        @(posedge core_clk);
        ev[w] <= 8'h00;
    endtask

    // The wait is bounded so that a request that never moves fails the compare after it.
    task automatic wait_srq(input logic lvl);
        for (int i = 0; i < 40 && srq !== lvl; i++) begin
            skip(1);
        end
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        logic [7:0] e;
        e = 8'hAD;
        rd_chk(ADDR_SRE, SRE_RESET);
        rd_chk(5'h1F, 8'h00);
        wr(ADDR_SRE, 8'hFF);
        rd_chk(ADDR_SRE, 8'hFF);
        wr(ADDR_SRE, 8'hA7);
        rd_chk(ADDR_SRE, 8'hA7);
        wr(5'h11, 8'h00);
        rd_chk(ADDR_SRE, 8'hA5);
        wr(5'h13, 8'h01);
        for (int i = 0; i < 8; i++) begin
            rd_chk(5'h10 + 5'(i), {7'h00, e[i]});
        end
        pulse(WORD_STD, 8'hFF);
        rd_chk(ADDR_STD_EVENT, 8'hFF);
        rd_chk(ADDR_STD_EVENT, 8'h00);
        wr(ADDR_SRE, 8'h00);
    endtask

    task automatic t_srq();
        wr(ADDR_STD_EN, 8'h01);
        wr(ADDR_SRE, 8'h20);
        wr(ADDR_INT_MASK, 8'h01);
        pulse(WORD_STD, 8'h01);
        skip(2);
        chk({6'h00, irq, srq}, 8'h03);
        wait_srq(1'b0);
        chk({7'h00, srq}, 8'h00);
        pulse(WORD_STD, 8'h01);
        skip(4);
        chk({7'h00, srq}, 8'h00);
        rd_chk(ADDR_INT_STATUS, 8'h03);
        wr(ADDR_INT_STATUS, 8'h03);
        wr(ADDR_INT_MASK, 8'h00);
        rd_chk(ADDR_STD_EVENT, 8'h01);
        skip(1);
        chk(poll_status & 8'h20, 8'h00);
        pulse(WORD_STD, 8'h01);
        skip(2);
        chk({6'h00, irq, srq}, 8'h01);
        reset_n <= 1'b0;
        #1;
        chk({7'h00, srq}, 8'h00);
        do_reset();
    endtask

    task automatic t_words();
        logic [4:0] wa [3] = '{ADDR_PROCESS, ADDR_GAUGE, ADDR_INSTR_ERR};
        logic [4:0] ea [3] = '{ADDR_PROCESS_EN, ADDR_GAUGE_EN, ADDR_INSTR_EN};
        logic [7:0] sb [3] = '{8'h01, 8'h02, 8'h04};
        for (int i = 0; i < 3; i++) begin
            wr(ea[i], 8'h10);
            pulse(WORD_PROCESS + i, 8'h03);
            skip(2);
            chk(poll_status & sb[i], 8'h00);
            pulse(WORD_PROCESS + i, 8'h10);
            skip(2);
            chk(poll_status & sb[i], sb[i]);
            rd_chk(wa[i], 8'h13);
            skip(1);
            chk(poll_status & sb[i], 8'h00);
        end
    endtask

    // A write while the clock enable is low must leave the register untouched.
    task automatic t_freeze();
        clk_en <= 1'b0;
        wr(ADDR_SRE, 8'hFF);
        clk_en <= 1'b1;
        rd_chk(ADDR_SRE, 8'h00);
    endtask

    task automatic t_aux();
        wr(ADDR_SRE, 8'h88);
        poll_delay <= 4'hC;
        status_aux <= 8'h80;
        wait_srq(1'b1);
        chk({7'h00, srq}, 8'h01);
        wait_srq(1'b0);
        skip(4);
        chk({7'h00, srq}, 8'h00);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_regs();
        t_freeze();
        t_srq();
        t_words();
        t_aux();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
endmodule
